// File: rtl/usw_pkg.sv
package usw_pkg;

  // register byte offsets
  localparam logic [7:0]  OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0]  OFF_CTRL_TWO   = 8'h04;
  localparam logic [7:0]  OFF_STATUS_ONE = 8'h08;
  localparam logic [7:0]  OFF_STATUS_TWO = 8'h0c;
  localparam logic [7:0]  OFF_DATA_PAIR  = 8'h10;
  localparam logic [7:0]  OFF_BAUD       = 8'h14;

  // field positions inside the 32-bit words
  localparam int unsigned CTL1_LSB  = 0;
  localparam int unsigned CTL1_W    = 5;
  localparam int unsigned CTL2_LSB  = 1;
  localparam int unsigned CTL2_W    = 7;
  localparam int unsigned FLAGS_LSB = 3;
  localparam int unsigned FLAGS_W   = 5;
  localparam int unsigned DIR_BIT   = 1;
  localparam int unsigned DATA_W    = 9;
  localparam int unsigned BAUD_W    = 16;

  // bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  // sample slot indices, slot n held as n-1
  localparam logic [3:0]  SLOT_VER_A = 4'h2;
  localparam logic [3:0]  SLOT_VER_B = 4'h4;
  localparam logic [3:0]  SLOT_VER_C = 4'h6;
  localparam logic [3:0]  SLOT_MAJ_A = 4'h7;
  localparam logic [3:0]  SLOT_MAJ_B = 4'h8;
  localparam logic [3:0]  SLOT_MAJ_C = 4'h9;
  localparam logic [3:0]  SLOT_LAST  = 4'hf;
  localparam logic [3:0]  SLOT_AFTER_EDGE = 4'h1;

  // frame shapes
  localparam logic [3:0]  DATA_BITS_8 = 4'h8;
  localparam logic [3:0]  DATA_BITS_9 = 4'h9;
  localparam logic [3:0]  TX_FRAME_8  = 4'ha;
  localparam logic [3:0]  TX_FRAME_9  = 4'hb;
  localparam logic [7:0]  QUIET_8     = 8'ha0;
  localparam logic [7:0]  QUIET_9     = 8'hb0;
  localparam logic [2:0]  HIST_HIGH   = 3'h7;

  // reset values
  localparam logic [15:0] BAUD_RESET  = 16'h0036;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } usw_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } usw_ahb_rsp_t;

  typedef struct packed {
    logic m9;
    logic wake;
    logic quiet_count_start_select;
    logic receiver_source_select;
    logic internal_feedback_select;
  } usw_ctl1_t;

  typedef struct packed {
    logic empty_irq_on;
    logic complete_irq_on;
    logic full_irq_on;
    logic quiet_irq_on;
    logic te;
    logic re;
    logic rx_standby;
  } usw_ctl2_t;

  typedef struct packed {
    logic tx_empty_flag;
    logic tc;
    logic rx_full_flag;
    logic idle;
    logic ovr;
  } usw_flags_t;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} usw_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SEND} usw_tx_state_t;

  typedef struct packed {
    usw_ctl1_t     ctl1;
    usw_ctl2_t     ctl2;
    logic          dir;
    logic [15:0]   baud;
    logic [15:0]   div_cnt;
    usw_flags_t    fl;
    usw_flags_t    arm;
    logic          idle_ok;
    logic [8:0]    rdr;
    logic [8:0]    tdr;
    logic          tx_pend;
    logic          rx_s1;
    logic          rx_s2;
    logic          pin_s1;
    logic          pin_s2;
    usw_rx_state_t rxs;
    logic [3:0]    rx_rt;
    logic [3:0]    rx_bits;
    logic [8:0]    rx_sh;
    logic [2:0]    smp;
    logic [2:0]    hist;
    logic [7:0]    quiet;
    usw_tx_state_t txs;
    logic [3:0]    tx_rt;
    logic [3:0]    tx_bits;
    logic [10:0]   tx_sh;
    logic          tx_line;
    logic          dp_on;
    logic          dp_wr;
    logic          rd_wait;
    logic [7:0]    dp_addr;
    logic [31:0]   rdata;
  } usw_st_t;

endpackage : usw_pkg

// File: rtl/usw_rx_wakeup.sv
// Behaviour
// R1 - stop sampled slots 8-10, finish slot 10
// R2 - standby: load data, no full flag
// R3 - exit method bit: 0 idle, 1 address
// R4 - idle line clears standby in idle mode
// R5 - waking idle sets neither quiet nor full
// R6 - quiet count starts after start or stop
// R7 - high data msb marks address frame, wakes
// R8 - wake before stop, address frame sets full
// R9 - standby on idle line may wake at once
// R10 - single wire: receiver fed from tx pin
// R11 - direction bit: tx pin input or output
// R12 - software enables tx and rx first
// R13 - loop: transmitter output feeds receiver
// R14 - five status flags at bits 7..3
// R15 - enabled flags ORed onto one interrupt; overrun has no enable, full and quiet held off in standby
// R16 - empty on load, read-then-write clears
// R17 - complete when empty and idle, line high
// R18 - complete clears by sequence or queueing
// R19 - full on transfer, read-then-read clears
// R20 - overrun keeps old data, same clearing
// R21 - quiet after 10/11 ones, rearm by frame
// R22 - quiet cleared by status then data read
// R23 - sixteen sample slots per bit time
// R24 - ninth bit select sets msb, threshold
module usw_rx_wakeup (
  input  logic                  clk_in,
  input  logic                  rst_b_in,
  input  usw_pkg::usw_ahb_req_t ahb_in,
  input  logic                  rxd_in,
  input  logic                  txd_pin_in,
  output usw_pkg::usw_ahb_rsp_t ahb_out,
  output logic                  txd_out,
  output logic                  txd_oe_out,
  output logic                  irq_out
);

  usw_pkg::usw_st_t st;
  usw_pkg::usw_st_t next_st;

  logic       rt_tick;
  logic       rx_bit;
  logic [2:0] smp_now;
  logic       maj_now;
  logic [3:0] data_bits;
  logic [7:0] quiet_lim;
  logic       quiet_full;
  logic       last_data;
  logic       rx_done;
  logic [8:0] frame_word;
  logic       tx_load;
  logic       accept;
  logic       rd_now;
  logic       wr_now;
  logic       ready;

  // two of three vote, shared by start, data and stop sampling
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : maj3

  // true on any of the three centre sample slots
  function automatic logic centre_slot(input logic [3:0] rt);
    centre_slot = (rt == usw_pkg::SLOT_MAJ_A) || (rt == usw_pkg::SLOT_MAJ_B) || (rt == usw_pkg::SLOT_MAJ_C);
  endfunction : centre_slot

  // sample clock at sixteen ticks per bit; divisor zero stops it
  assign rt_tick = (st.baud != '0) && (st.div_cnt >= st.baud - 16'h0001); // see R23

  // receiver source selection; the raw pin is cut off whenever internal_feedback_select is set
  assign rx_bit = st.ctl1.internal_feedback_select ? (st.ctl1.receiver_source_select ? st.pin_s2 : st.tx_line) : st.rx_s2; // see R10 see R13

  assign smp_now    = {st.smp[1:0], rx_bit};
  assign maj_now    = maj3(smp_now);
  assign data_bits  = st.ctl1.m9 ? usw_pkg::DATA_BITS_9 : usw_pkg::DATA_BITS_8; // see R24
  assign quiet_lim  = st.ctl1.m9 ? usw_pkg::QUIET_9 : usw_pkg::QUIET_8; // see R21
  assign quiet_full = st.ctl2.re && (st.quiet == quiet_lim);
  assign last_data  = (st.rx_bits == data_bits - 4'h1);
  // frame ends at slot 10 of the stop bit, only with a good stop vote
  assign rx_done    = rt_tick && st.ctl2.re && (st.rxs == usw_pkg::RX_STOP)
                      && (st.rx_rt == usw_pkg::SLOT_MAJ_C) && maj_now; // see R1
  assign frame_word = st.ctl1.m9 ? st.rx_sh : {1'h0, st.rx_sh[8:1]};
  assign tx_load    = (st.txs == usw_pkg::TX_IDLE) && st.tx_pend && st.ctl2.te;

  // bus phases; reads take one wait state so read data comes from a flop
  assign accept = ahb_in.hsel && (ahb_in.htrans == usw_pkg::HTRANS_NONSEQ) && ahb_in.hready;
  assign rd_now = st.dp_on && !st.dp_wr && !st.rd_wait;
  assign wr_now = st.dp_on && st.dp_wr;
  assign ready  = !rd_now;

  assign ahb_out.hrdata    = st.rdata;
  assign ahb_out.hreadyout = ready;
  assign ahb_out.hresp     = usw_pkg::HRESP_OKAY;

  // pin drivers; shared wire turns round on the direction bit
  assign txd_out    = st.tx_line;
  assign txd_oe_out = !(st.ctl1.internal_feedback_select && st.ctl1.receiver_source_select && !st.dir); // see R11

  // full and quiet terms are held off in standby, overrun has no enable
  assign irq_out = (st.fl.tx_empty_flag & st.ctl2.empty_irq_on) | (st.fl.tc & st.ctl2.complete_irq_on) | st.fl.ovr
                   | (!st.ctl2.rx_standby & ((st.fl.rx_full_flag & st.ctl2.full_irq_on) | (st.fl.idle & st.ctl2.quiet_irq_on))); // see R15

  // whole next-state computation; hardware sets come last so they beat clears
  always_comb
  begin
    next_st = st;
    // pin synchronisers
    next_st.rx_s1  = rxd_in;
    next_st.rx_s2  = st.rx_s1;
    next_st.pin_s1 = txd_pin_in;
    next_st.pin_s2 = st.pin_s1;
    // sample clock divider
    if (st.baud == '0 || rt_tick)
      next_st.div_cnt = '0;
    else
      next_st.div_cnt = st.div_cnt + 16'h0001;

    // bus address phase capture
    if (ready)
    begin
      next_st.dp_on   = accept;
      next_st.dp_wr   = ahb_in.hwrite;
      next_st.dp_addr = ahb_in.haddr[7:0];
      next_st.rd_wait = 1'h0;
    end
    else
      next_st.rd_wait = 1'h1;

    // read data and read side effects
    if (rd_now)
    begin
      next_st.rdata = '0;
      case (st.dp_addr)
        usw_pkg::OFF_CTRL_ONE:
          next_st.rdata[usw_pkg::CTL1_LSB +: usw_pkg::CTL1_W] = st.ctl1;
        usw_pkg::OFF_CTRL_TWO:
          next_st.rdata[usw_pkg::CTL2_LSB +: usw_pkg::CTL2_W] = st.ctl2;
        usw_pkg::OFF_STATUS_ONE:
        begin
          next_st.rdata[usw_pkg::FLAGS_LSB +: usw_pkg::FLAGS_W] = st.fl; // see R14
          next_st.arm = st.fl; // only flags seen set may be cleared later
        end
        usw_pkg::OFF_STATUS_TWO:
          next_st.rdata[usw_pkg::DIR_BIT] = st.dir;
        usw_pkg::OFF_DATA_PAIR:
        begin
          next_st.rdata[usw_pkg::DATA_W-1:0] = st.rdr;
          if (st.arm.rx_full_flag)
            next_st.fl.rx_full_flag = 1'h0; // see R19
          if (st.arm.ovr)
            next_st.fl.ovr = 1'h0; // see R20
          if (st.arm.idle)
            next_st.fl.idle = 1'h0; // see R22
          next_st.arm.rx_full_flag = 1'h0;
          next_st.arm.ovr  = 1'h0;
          next_st.arm.idle = 1'h0;
        end
        usw_pkg::OFF_BAUD:
          next_st.rdata[usw_pkg::BAUD_W-1:0] = st.baud;
        default:
          next_st.rdata = '0;
      endcase
    end

    // register writes; unmapped writes are dropped
    if (wr_now)
    begin
      case (st.dp_addr)
        usw_pkg::OFF_CTRL_ONE:
          next_st.ctl1 = ahb_in.hwdata[usw_pkg::CTL1_LSB +: usw_pkg::CTL1_W]; // see R3 see R6
        usw_pkg::OFF_CTRL_TWO:
          next_st.ctl2 = ahb_in.hwdata[usw_pkg::CTL2_LSB +: usw_pkg::CTL2_W]; // see R2
        usw_pkg::OFF_STATUS_TWO:
          next_st.dir = ahb_in.hwdata[usw_pkg::DIR_BIT];
        usw_pkg::OFF_DATA_PAIR:
        begin
          next_st.tdr     = ahb_in.hwdata[usw_pkg::DATA_W-1:0];
          next_st.tx_pend = 1'h1;
          if (st.arm.tx_empty_flag)
            next_st.fl.tx_empty_flag = 1'h0; // see R16
          if (st.arm.tc)
            next_st.fl.tc = 1'h0; // see R18
          next_st.arm.tx_empty_flag = 1'h0;
          next_st.arm.tc   = 1'h0;
        end
        usw_pkg::OFF_BAUD:
          next_st.baud = ahb_in.hwdata[usw_pkg::BAUD_W-1:0];
        default:
          next_st.baud = st.baud;
      endcase
    end

    // receiver; idle when disabled so a late enable starts clean
    if (!st.ctl2.re)
    begin
      next_st.rxs   = usw_pkg::RX_HUNT;
      next_st.quiet = '0;
      next_st.hist  = '0;
    end
    else if (rt_tick)
    begin
      next_st.hist  = {st.hist[1:0], rx_bit};
      next_st.rx_rt = st.rx_rt + 4'h1;
      // quiet count: a zero restarts it; with ilt set the frame body does too
      if (!rx_bit || (st.ctl1.quiet_count_start_select && st.rxs != usw_pkg::RX_HUNT))
        next_st.quiet = '0; // see R6
      else if (st.quiet != quiet_lim)
        next_st.quiet = st.quiet + 8'h01; // see R21
      if (centre_slot(st.rx_rt) || st.rx_rt == usw_pkg::SLOT_VER_A
          || st.rx_rt == usw_pkg::SLOT_VER_B || st.rx_rt == usw_pkg::SLOT_VER_C)
        next_st.smp = smp_now;
      case (st.rxs)
        usw_pkg::RX_HUNT:
        begin
          next_st.rx_rt = '0;
          // falling edge after three highs starts the frame
          if (!rx_bit && st.hist == usw_pkg::HIST_HIGH)
          begin
            next_st.rxs   = usw_pkg::RX_START;
            next_st.rx_rt = usw_pkg::SLOT_AFTER_EDGE;
          end
        end
        usw_pkg::RX_START:
        begin
          // noise that votes high at slots 3, 5, 7 restarts the search
          if (st.rx_rt == usw_pkg::SLOT_VER_C && maj_now)
            next_st.rxs = usw_pkg::RX_HUNT;
          else if (st.rx_rt == usw_pkg::SLOT_LAST)
          begin
            next_st.rxs     = usw_pkg::RX_DATA;
            next_st.rx_bits = '0;
          end
        end
        usw_pkg::RX_DATA:
        begin
          if (st.rx_rt == usw_pkg::SLOT_MAJ_C)
          begin
            next_st.rx_sh = {maj_now, st.rx_sh[8:1]};
            // address mark wakes before the stop bit arrives
            if (last_data && maj_now && st.ctl1.wake && st.ctl2.rx_standby)
              next_st.ctl2.rx_standby = 1'h0; // see R7 see R8 see R24
          end
          if (st.rx_rt == usw_pkg::SLOT_LAST)
          begin
            next_st.rx_bits = st.rx_bits + 4'h1;
            if (last_data)
              next_st.rxs = usw_pkg::RX_STOP;
          end
        end
        usw_pkg::RX_STOP:
        begin
          // stop votes at slots 8-10, then hunt at once to tolerate fast senders
          if (st.rx_rt == usw_pkg::SLOT_MAJ_C)
            next_st.rxs = usw_pkg::RX_HUNT; // see R1
        end
        default:
          next_st.rxs = usw_pkg::RX_HUNT;
      endcase
    end

    // completed frame lands in the data register unless it overruns
    if (rx_done)
    begin
      if (st.ctl2.rx_standby)
        next_st.rdr = frame_word; // see R2
      else if (next_st.fl.rx_full_flag)
        next_st.fl.ovr = 1'h1; // see R20
      else
      begin
        next_st.rdr     = frame_word;
        next_st.fl.rx_full_flag = 1'h1; // see R19 see R8
        next_st.idle_ok = 1'h1; // see R21
      end
    end

    // idle line: wake in idle mode, else raise the quiet flag once
    if (quiet_full)
    begin
      if (st.ctl2.rx_standby && !st.ctl1.wake)
      begin
        next_st.ctl2.rx_standby = 1'h0; // see R4 see R9
        next_st.idle_ok  = 1'h0; // see R5
      end
      else if (!st.ctl2.rx_standby && st.idle_ok)
      begin
        next_st.fl.idle = 1'h1; // see R21
        next_st.idle_ok = 1'h0;
      end
    end

    // transmitter; tick phase is not aligned to the load, start bit may lose a tick
    if (!st.ctl2.te)
    begin
      next_st.txs     = usw_pkg::TX_IDLE;
      next_st.tx_line = 1'h1;
    end
    else if (tx_load)
    begin
      next_st.txs     = usw_pkg::TX_SEND;
      next_st.tx_rt   = '0;
      next_st.tx_line = 1'h0;
      next_st.tx_pend = 1'h0;
      next_st.fl.tx_empty_flag = 1'h1; // see R16
      if (st.ctl1.m9)
      begin
        next_st.tx_sh   = {2'h3, st.tdr};
        next_st.tx_bits = usw_pkg::TX_FRAME_9 - 4'h1;
      end
      else
      begin
        next_st.tx_sh   = {3'h7, st.tdr[7:0]};
        next_st.tx_bits = usw_pkg::TX_FRAME_8 - 4'h1;
      end
    end
    else if (st.txs == usw_pkg::TX_SEND && rt_tick)
    begin
      next_st.tx_rt = st.tx_rt + 4'h1;
      if (st.tx_rt == usw_pkg::SLOT_LAST)
      begin
        if (st.tx_bits == '0)
        begin
          next_st.txs     = usw_pkg::TX_IDLE;
          next_st.tx_line = 1'h1; // see R17
        end
        else
        begin
          next_st.tx_line = st.tx_sh[0];
          next_st.tx_sh   = {1'h1, st.tx_sh[10:1]};
          next_st.tx_bits = st.tx_bits - 4'h1;
        end
      end
    end

    // complete flag: queued data clears it, an idle empty transmitter sets it
    if (next_st.tx_pend)
      next_st.fl.tc = 1'h0; // see R18
    else if (st.fl.tx_empty_flag && st.txs == usw_pkg::TX_IDLE && !tx_load)
      next_st.fl.tc = 1'h1; // see R17
  end

  // state register; reset values are constants only
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st         <= '0;
      st.baud    <= usw_pkg::BAUD_RESET;
      st.fl.tx_empty_flag <= 1'h1;
      st.fl.tc   <= 1'h1;
      st.idle_ok <= 1'h1;
      st.tx_line <= 1'h1;
      st.rx_s1   <= 1'h1;
      st.rx_s2   <= 1'h1;
      st.pin_s1  <= 1'h1;
      st.pin_s2  <= 1'h1;
    end
    else
      st <= next_st;
  end

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // frame completes on the stop bit's tenth slot, hunting right after
  chk_stop_slot: assert property (rx_done |-> st.rx_rt == usw_pkg::SLOT_MAJ_C ##1 st.rxs == usw_pkg::RX_HUNT) // see R1
    else $error("frame did not finish at stop slot ten");

  // standby loads data but leaves the full flag alone
  chk_standby_load: assert property (rx_done && st.ctl2.rx_standby && !st.fl.rx_full_flag
                                     |=> !st.fl.rx_full_flag && st.rdr == $past(frame_word)) // see R2
    else $error("standby frame raised full flag or was not loaded");

  // address mark clears standby at the last data bit
  chk_addr_wake: assert property (rt_tick && st.ctl2.re && st.rxs == usw_pkg::RX_DATA && last_data
                                  && st.rx_rt == usw_pkg::SLOT_MAJ_C && maj_now && st.ctl1.wake
                                  && st.ctl2.rx_standby |=> !st.ctl2.rx_standby) // see R7
    else $error("address frame did not clear standby");

  // idle line wakes without raising the quiet flag
  chk_quiet_wake: assert property (quiet_full && st.ctl2.rx_standby && !st.ctl1.wake && !st.fl.idle
                                   |=> !st.ctl2.rx_standby && !st.fl.idle ##1 !st.fl.idle) // see R4
    else $error("idle wake failed or raised quiet flag");

  chk_loop_path: assert property (st.ctl1.internal_feedback_select && !st.ctl1.receiver_source_select |-> rx_bit == st.tx_line) // see R13
    else $error("loop mode receiver not fed by transmitter");

  chk_single_dir: assert property (st.ctl1.internal_feedback_select && st.ctl1.receiver_source_select |-> txd_oe_out == st.dir) // see R11
    else $error("shared pin direction wrong");

  // load into the shifter raises empty and starts the start bit
  chk_tx_empty: assert property (tx_load |=> st.fl.tx_empty_flag && st.txs == usw_pkg::TX_SEND && !txd_out) // see R16
    else $error("transmit load did not set empty flag");

  chk_tc_line: assert property (st.fl.tc |-> txd_out) // see R17
    else $error("line not high while transmit complete");

  chk_full_set: assert property (rx_done && !st.ctl2.rx_standby && !st.fl.rx_full_flag
                                 |=> st.fl.rx_full_flag && st.rdr == $past(frame_word)) // see R19
    else $error("received frame did not set full flag");

  // overrun keeps the old word
  chk_overrun: assert property (rx_done && !st.ctl2.rx_standby && st.fl.rx_full_flag && !(rd_now && st.arm.rx_full_flag)
                                |=> st.fl.ovr && $stable(st.rdr)) // see R20
    else $error("overrun not flagged or data overwritten");

  chk_irq_full: assert property (st.fl.rx_full_flag && st.ctl2.full_irq_on && !st.ctl2.rx_standby |-> irq_out) // see R15
    else $error("enabled full flag not on interrupt");

endmodule : usw_rx_wakeup

// File: tb/async_serial_rx_wakeup_irq_test.sv
module async_serial_rx_wakeup_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BIT_CYC = 32; // 16 ticks at divisor 2
  localparam int unsigned LIMIT   = 40000;
  logic                  clk_in, rst_b_in, hold_low, sel, write;
  logic [31:0]           addr, wdata, rd;
  logic [1:0]            trans;
  logic [2:0]            size;
  usw_pkg::usw_ahb_req_t ahb_in;
  usw_pkg::usw_ahb_rsp_t ahb_out;
  logic                  txd_out, txd_oe_out, irq_out, line, rxd_in, txd_pin, ok;
  logic [7:0]            rx;
  int                    miscompares, comparisons, cycles;
  // one slave, so its hreadyout is the bus hready
  assign ahb_in = {sel, addr, trans, write, size, wdata, ahb_out.hreadyout};
  // inverted far-end line shows the pin is cut off in loop modes
  assign rxd_in = line ^ hold_low;
  // shared wire: the design wins while it drives, the far end otherwise
  assign txd_pin = txd_oe_out ? txd_out : line;
  usw_rx_wakeup dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .ahb_in(ahb_in), .rxd_in(rxd_in),
    .txd_pin_in(txd_pin), .ahb_out(ahb_out), .txd_out(txd_out), .txd_oe_out(txd_oe_out), .irq_out(irq_out));
  usw_far_end #(.BIT_CYC(BIT_CYC)) pm_u (.clk_in(clk_in), .txd_in(txd_pin), .line_out(line));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask : cmp_bit
  // each phase held until hready is sampled high at a rising edge; read data taken at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_in);
    sel   <= 1'b1;
    trans <= usw_pkg::HTRANS_NONSEQ;
    addr  <= {24'h0, a};
    write <= wr;
    size  <= 3'h2;
    do @(posedge clk_in); while (ahb_out.hreadyout !== 1'b1);
    sel   <= 1'b0;
    trans <= 2'h0;
    wdata <= d;
    do @(posedge clk_in); while (ahb_out.hreadyout !== 1'b1);
    r = ahb_out.hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    cmp_word(rd, exp);
  endtask : chk_rd
  // waits end just past the edge so flop outputs have settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wait_cyc
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  initial
  begin
    {sel, write, addr, wdata, trans, size} = '0;
    hold_low = 1'b0;
    rst_b_in = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chk_rd(usw_pkg::OFF_CTRL_ONE, 32'h0);
    chk_rd(usw_pkg::OFF_CTRL_TWO, 32'h0);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    chk_rd(usw_pkg::OFF_BAUD, {16'h0, usw_pkg::BAUD_RESET});
    chk_rd(8'h18, 32'h0);
    cmp_bit(irq_out, 1'b0);
    cmp_bit(ahb_out.hresp, usw_pkg::HRESP_OKAY);
    note("reset");
    wr(usw_pkg::OFF_BAUD, 32'h2);
    wr(usw_pkg::OFF_CTRL_TWO, 32'h0c);
    wr(usw_pkg::OFF_DATA_PAIR, 32'ha5);
    pm_u.recv(rx, ok);
    cmp_word({24'h0, rx}, 32'ha5);
    cmp_bit(ok, 1'b1);
    wait_cyc(BIT_CYC);
    cmp_bit(txd_out, 1'b1);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hd0);
    note("transmit");
    pm_u.send(8'h3c);
    pm_u.send(8'hc3);
    wait_cyc(2);
    cmp_bit(irq_out, 1'b1);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hf8);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h3c);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    wait_cyc(400);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hd0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h3c);
    wait_cyc(400);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    note("receive");
    wr(usw_pkg::OFF_CTRL_ONE, 32'h08);
    wr(usw_pkg::OFF_CTRL_TWO, 32'h2e);
    pm_u.send(8'h12);
    wait_cyc(8);
    cmp_bit(irq_out, 1'b0);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h12);
    pm_u.send(8'h81);
    wait_cyc(8);
    cmp_bit(irq_out, 1'b1);
    chk_rd(usw_pkg::OFF_CTRL_TWO, 32'h2c);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'he0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h81);
    note("address wake");
    wr(usw_pkg::OFF_CTRL_ONE, 32'h0);
    // standby is entered mid-frame, as an early idle line may wake at once
    fork
      pm_u.send(8'h55);
      begin
        wait_cyc(BIT_CYC * 3);
        wr(usw_pkg::OFF_CTRL_TWO, 32'h0e);
      end
    join
    chk_rd(usw_pkg::OFF_CTRL_TWO, 32'h0e);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    wait_cyc(400);
    chk_rd(usw_pkg::OFF_CTRL_TWO, 32'h0c);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    note("idle wake");
    hold_low <= 1'b1;
    wr(usw_pkg::OFF_CTRL_ONE, 32'h01);
    wr(usw_pkg::OFF_DATA_PAIR, 32'h5a);
    wait_cyc(BIT_CYC * 11);
    cmp_bit(txd_oe_out, 1'b1);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'he0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h5a);
    wr(usw_pkg::OFF_CTRL_ONE, 32'h03);
    wr(usw_pkg::OFF_STATUS_TWO, 32'h0);
    wait_cyc(2);
    cmp_bit(txd_oe_out, 1'b0);
    pm_u.send(8'h96);
    wait_cyc(8);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'he0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h96);
    wr(usw_pkg::OFF_STATUS_TWO, 32'h2);
    wait_cyc(2);
    cmp_bit(txd_oe_out, 1'b1);
    chk_rd(usw_pkg::OFF_STATUS_TWO, 32'h2);
    note("loop and single wire");
    wr(usw_pkg::OFF_CTRL_TWO, 32'h4c);
    wait_cyc(1);
    cmp_bit(irq_out, 1'b1);
    note("complete interrupt");
    // nine-bit frame, quiet count from the stop bit: 176 ticks, not 160
    hold_low <= 1'b0;
    wr(usw_pkg::OFF_CTRL_ONE, 32'h14);
    pm_u.send(9'h1a5, 9);
    wait_cyc(8);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'he0);
    chk_rd(usw_pkg::OFF_DATA_PAIR, 32'h1a5);
    wait_cyc(300);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hc0);
    wait_cyc(40);
    chk_rd(usw_pkg::OFF_STATUS_ONE, 32'hd0);
    note("nine bit quiet");
    summarize();
  end
endmodule : async_serial_rx_wakeup_irq_test

// File: tb/usw_far_end.sv
module usw_far_end #(
  parameter int unsigned BIT_CYC = 32
) (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a marking line rests high between frames
  initial line_out = 1'b1;
  // start low, eight or nine bits lsb first, one stop bit held for a full bit time
  task automatic send(input logic [8:0] data, input int nbits = 8);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_in);
    for (int i = 0; i < nbits; i++)
    begin
      line_out <= data[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_in);
  endtask : send
  // mid-bit sampling keeps clear of the launching edges
  task automatic recv(output logic [7:0] data, output logic ok);
    int n;
    n = 0;
    while (txd_in !== 1'b0 && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
    ok = (n < 4000);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      data[i] = txd_in;
    end
    repeat (BIT_CYC) @(posedge clk_in);
    ok = ok & (txd_in === 1'b1);
  endtask : recv
endmodule : usw_far_end
